/* File: common/uart_cfg_pkg.sv */
// Purpose: Shared constants and types for the serial channel configuration block
// Assumes: 32-bit Avalon-MM register bus with byte addresses
// Notes:   Trigger levels are character counts of a 64-entry FIFO
package uart_cfg_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [5:0] OFS_FIFO_CTL   = 6'h00;
	localparam logic [5:0] OFS_LINE_FMT   = 6'h04;
	localparam logic [5:0] OFS_FEATURE    = 6'h08;
	localparam logic [5:0] OFS_ENHANCED   = 6'h0c;
	localparam logic [5:0] OFS_TRIG_LEVEL = 6'h10;
	localparam logic [5:0] OFS_IRQ_STATUS = 6'h14;
	localparam logic [5:0] OFS_IRQ_ENABLE = 6'h18;
	localparam logic [5:0] OFS_IRQ_CLEAR  = 6'h1c;
	localparam logic [5:0] OFS_TRIG_STAT  = 6'h20;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int FC_ENABLE    = 0;
	localparam int FC_TX_RESET  = 2;
	localparam int FC_DMA       = 3;
	localparam int FC_TX_TRIG   = 4;
	localparam int FC_RX_TRIG   = 6;
	localparam int LF_WLEN      = 0;
	localparam int LF_STOP      = 2;
	localparam int LF_PAR_EN    = 3;
	localparam int LF_PAR_EVEN  = 4;
	localparam int LF_PAR_FORCE = 5;
	localparam int FT_TABLE     = 4;
	localparam int FT_TRG_TX    = 7;
	localparam int EF_ENHANCED  = 4;
	localparam int IRQ_RX       = 0;
	localparam int IRQ_TX       = 1;
	localparam int IRQ_N        = 2;
	localparam int TS_RX_LVL    = 0;
	localparam int TS_TX_LVL    = 8;
	localparam int TS_TABLE     = 16;
	localparam int TS_DMA       = 18;
	localparam int TS_FIFO_EN   = 19;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef logic [6:0] level_t;
	typedef enum logic [1:0] {TABLE_A, TABLE_B, TABLE_C, TABLE_D} trig_table_t;

	typedef struct packed {
		logic [3:0] data_bits;
		logic [2:0] stop_half_bits;
		logic       parity_en;
		logic       parity_even;
		logic       parity_forced;
	} line_format_t;

	typedef struct packed {
		level_t      rx_level;
		level_t      tx_level;
		trig_table_t table_sel;
		logic        dma_mode;
		logic        fifo_en;
	} trig_cfg_t;

	////////////////////////////////////////////////////////////////////////////
	// Trigger tables, indexed by the two-bit select code
	localparam level_t RX_TAB_A [4] = '{7'h01, 7'h04, 7'h08, 7'h0e};
	localparam level_t RX_TAB_B [4] = '{7'h08, 7'h10, 7'h18, 7'h1c};
	localparam level_t RX_TAB_C [4] = '{7'h08, 7'h10, 7'h38, 7'h3c};
	localparam level_t TX_TAB_B [4] = '{7'h10, 7'h08, 7'h18, 7'h1e};
	localparam level_t TX_TAB_C [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
	localparam level_t TX_LVL_A     = 7'h01;
	localparam level_t TRG_RESET    = 7'h01;

	localparam logic [3:0] WLEN_BASE   = 4'h5;
	localparam logic [2:0] STOP_ONE    = 3'h2;
	localparam logic [2:0] STOP_ONEH   = 3'h3;
	localparam logic [2:0] STOP_TWO    = 3'h4;
	localparam logic [1:0] WLEN_FIVE   = 2'h0;
	localparam logic [7:0] LF_RESET    = 8'h00;

endpackage

/* File: hdl/uart_cfg.sv */
// Purpose: Per-channel FIFO trigger, ready pin and line format configuration
// Assumes: FIFO counts come from logic on core_clk_i
// Notes:   Register bus answers after one wait cycle
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module uart_cfg
	import uart_cfg_pkg::*;
#(
	parameter int DEPTH = 64,
	parameter int CNT_W = 7
)(
	input  wire logic              core_clk_i,       // Block clock
	input  wire logic              rst_i,            // Async reset, high
	input  wire logic [5:0]        address_i,        // Avalon byte address
	input  wire logic              read_i,           // Avalon read
	input  wire logic              write_i,          // Avalon write
	input  wire logic [31:0]       writedata_i,      // Avalon write data
	output logic      [31:0]       readdata_o,       // Avalon read data
	output logic                   waitrequest_o,    // Avalon wait
	input  wire logic [CNT_W-1:0]  tx_count_i,       // TX FIFO fill
	input  wire logic [CNT_W-1:0]  rx_count_i,       // RX FIFO fill
	input  wire logic [7:0]        tx_char_i,        // Char to send
	input  wire logic [7:0]        rx_char_i,        // Char received
	input  wire logic              rx_parity_i,      // Received parity bit
	output logic                   tx_fifo_clear_o,  // TX FIFO pointer clear
	output logic                   tx_ready_pin_n_o, // TX ready pin
	output logic                   rx_ready_pin_n_o, // RX ready pin
	output trig_cfg_t              trig_cfg_o,       // Trigger settings
	output line_format_t           line_fmt_o,       // Line format
	output logic                   tx_parity_o,      // Parity bit to send
	output logic                   rx_parity_err_o,  // Received parity bad
	output logic                   irq_o             // Interrupt, high
);

	////////////////////////////////////////////////////////////////////////////
	// Bus slave

	logic              ack;
	logic              wr_en;
	logic              rd_en;
	logic              fifo_en;
	logic              dma_mode;
	logic [1:0]        tx_trig;
	logic [1:0]        rx_trig;
	logic [7:0]        line_fmt_reg;
	logic [7:0]        feature_control;
	logic [7:0]        enhanced_feature_enable_reg;
	level_t            trg_rx;
	level_t            trg_tx;
	logic [IRQ_N-1:0]  irq_status;
	logic [IRQ_N-1:0]  irq_enable;
	logic [IRQ_N-1:0]  irq_set;
	logic [IRQ_N-1:0]  irq_clr;
	level_t            next_rx_level;
	level_t            next_tx_level;
	trig_table_t       table_sel;
	logic              fc_write;
	logic [CNT_W-1:0]  tx_prev;
	logic [CNT_W-1:0]  rx_prev;
	logic              filled_over;
	logic [31:0]       next_rdata;

	// One wait cycle keeps the decode and read mux off the bus timing path
	assign waitrequest_o = (read_i | write_i) & ~ack;
	assign wr_en         = write_i & ack;
	assign rd_en         = read_i & ~ack;
	assign fc_write      = wr_en && address_i == OFS_FIFO_CTL;

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			ack <= 1'b0;
		else
			ack <= (read_i | write_i) & ~ack;
	end

	always_comb
	begin
		next_rdata = '0;
		unique case (address_i)
			OFS_LINE_FMT:   next_rdata[7:0] = line_fmt_reg;
			OFS_FEATURE:    next_rdata[7:0] = feature_control;
			OFS_ENHANCED:   next_rdata[7:0] = enhanced_feature_enable_reg;
			OFS_TRIG_LEVEL: next_rdata[6:0] = feature_control[FT_TRG_TX] ? trg_tx : trg_rx;
			OFS_IRQ_STATUS: next_rdata[IRQ_N-1:0] = irq_status;
			OFS_IRQ_ENABLE: next_rdata[IRQ_N-1:0] = irq_enable;
			OFS_TRIG_STAT:
			begin
				next_rdata[TS_RX_LVL +: 7] = trig_cfg_o.rx_level;
				next_rdata[TS_TX_LVL +: 7] = trig_cfg_o.tx_level;
				next_rdata[TS_TABLE +: 2]  = trig_cfg_o.table_sel;
				next_rdata[TS_DMA]         = trig_cfg_o.dma_mode;
				next_rdata[TS_FIFO_EN]     = trig_cfg_o.fifo_en;
			end
			default:        next_rdata = '0;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			readdata_o <= '0;
		else if (rd_en)
			readdata_o <= next_rdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// FIFO control register

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			fifo_en  <= 1'b0;
			dma_mode <= 1'b0;
			tx_trig  <= 2'h0;
			rx_trig  <= 2'h0;
		end
		else if (fc_write)
		begin
			fifo_en <= writedata_i[FC_ENABLE];
			if (writedata_i[FC_ENABLE])
			begin
				dma_mode <= writedata_i[FC_DMA];
				rx_trig  <= writedata_i[FC_RX_TRIG +: 2];
				if (enhanced_feature_enable_reg[EF_ENHANCED])
					tx_trig <= writedata_i[FC_TX_TRIG +: 2];
			end
		end
	end

	// Self-clearing: the bit never reads back, only this pulse remains
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			tx_fifo_clear_o <= 1'b0;
		else
			tx_fifo_clear_o <= fc_write & writedata_i[FC_ENABLE]
				& writedata_i[FC_TX_RESET];
	end

	////////////////////////////////////////////////////////////////////////////
	// Feature, enhanced and programmable trigger registers

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			feature_control             <= 8'h00;
			enhanced_feature_enable_reg <= 8'h00;
		end
		else if (wr_en)
		begin
			if (address_i == OFS_FEATURE)
				feature_control <= writedata_i[7:0];
			if (address_i == OFS_ENHANCED)
				enhanced_feature_enable_reg <= writedata_i[7:0];
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			trg_rx <= TRG_RESET;
			trg_tx <= TRG_RESET;
		end
		else if (wr_en && address_i == OFS_TRIG_LEVEL)
		begin
			if (feature_control[FT_TRG_TX])
				trg_tx <= writedata_i[6:0];
			else
				trg_rx <= writedata_i[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trigger level lookup

	assign table_sel = trig_table_t'(feature_control[FT_TABLE +: 2]);

	// A single table select feeds both lookups, so RX and TX always come from the same table
	always_comb
	begin
		unique case (table_sel)
			TABLE_A:
			begin
				next_rx_level = RX_TAB_A[rx_trig];
				next_tx_level = TX_LVL_A;
			end
			TABLE_B:
			begin
				next_rx_level = RX_TAB_B[rx_trig];
				next_tx_level = TX_TAB_B[tx_trig];
			end
			TABLE_C:
			begin
				next_rx_level = RX_TAB_C[rx_trig];
				next_tx_level = TX_TAB_C[tx_trig];
			end
			TABLE_D:
			begin
				next_rx_level = trg_rx;
				next_tx_level = trg_tx;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			trig_cfg_o.rx_level  <= RX_TAB_A[0];
			trig_cfg_o.tx_level  <= TX_LVL_A;
			trig_cfg_o.table_sel <= TABLE_A;
			trig_cfg_o.dma_mode  <= 1'b0;
			trig_cfg_o.fifo_en   <= 1'b0;
		end
		else
		begin
			trig_cfg_o.rx_level  <= next_rx_level;
			trig_cfg_o.tx_level  <= next_tx_level;
			trig_cfg_o.table_sel <= table_sel;
			trig_cfg_o.dma_mode  <= dma_mode;
			trig_cfg_o.fifo_en   <= fifo_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Ready pins

	// Normal: single-character readiness; DMA: block readiness
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rx_ready_pin_n_o <= 1'b1;
			tx_ready_pin_n_o <= 1'b1;
		end
		else if (dma_mode)
		begin
			rx_ready_pin_n_o <= !(rx_count_i >= CNT_W'(trig_cfg_o.rx_level));
			tx_ready_pin_n_o <= !(tx_count_i < CNT_W'(DEPTH));
		end
		else
		begin
			rx_ready_pin_n_o <= rx_count_i == '0;
			tx_ready_pin_n_o <= tx_count_i != '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trigger events

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tx_prev <= '0;
			rx_prev <= '0;
		end
		else
		begin
			tx_prev <= tx_count_i;
			rx_prev <= rx_count_i;
		end
	end

	// Remembers whether the last refill went above the TX level
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			filled_over <= 1'b0;
		else if (tx_count_i > CNT_W'(trig_cfg_o.tx_level))
			filled_over <= 1'b1;
		else if (tx_count_i == '0)
			filled_over <= 1'b0;
	end

	always_comb
	begin
		irq_set         = '0;
		irq_set[IRQ_TX] = fifo_en
			&& ((tx_prev >= CNT_W'(trig_cfg_o.tx_level)
				&& tx_count_i < CNT_W'(trig_cfg_o.tx_level))
			|| (tx_prev != '0 && tx_count_i == '0 && !filled_over));
		irq_set[IRQ_RX] = fifo_en
			&& rx_prev < CNT_W'(trig_cfg_o.rx_level)
			&& rx_count_i >= CNT_W'(trig_cfg_o.rx_level);
		irq_clr = (wr_en && address_i == OFS_IRQ_CLEAR) ?
			writedata_i[IRQ_N-1:0] : '0;
	end

	// A new event beats a clear in the same cycle
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_status <= '0;
		else
			irq_status <= (irq_status & ~irq_clr) | irq_set;
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_enable <= '0;
		else if (wr_en && address_i == OFS_IRQ_ENABLE)
			irq_enable <= writedata_i[IRQ_N-1:0];
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(((irq_status & ~irq_clr) | irq_set) & irq_enable);
	end

	////////////////////////////////////////////////////////////////////////////
	// Line format

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			line_fmt_reg <= LF_RESET;
		else if (wr_en && address_i == OFS_LINE_FMT)
			line_fmt_reg <= writedata_i[7:0];
	end

	function automatic logic parity_of(input logic [7:0] ch, input line_format_t f);
		logic [7:0] mask;
		logic       ones;
		mask = 8'hff >> (4'h8 - f.data_bits);
		ones = ^(ch & mask);
		if (f.parity_forced)
			parity_of = ~f.parity_even;
		else
			parity_of = f.parity_even ? ones : ~ones;
	endfunction

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			line_fmt_o.data_bits      <= WLEN_BASE;
			line_fmt_o.stop_half_bits <= STOP_ONE;
			line_fmt_o.parity_en      <= 1'b0;
			line_fmt_o.parity_even    <= 1'b0;
			line_fmt_o.parity_forced  <= 1'b0;
		end
		else
		begin
			line_fmt_o.data_bits <= WLEN_BASE
				+ {2'h0, line_fmt_reg[LF_WLEN +: 2]};
			if (!line_fmt_reg[LF_STOP])
				line_fmt_o.stop_half_bits <= STOP_ONE;
			else if (line_fmt_reg[LF_WLEN +: 2] == WLEN_FIVE)
				line_fmt_o.stop_half_bits <= STOP_ONEH;
			else
				line_fmt_o.stop_half_bits <= STOP_TWO;
			line_fmt_o.parity_en     <= line_fmt_reg[LF_PAR_EN];
			line_fmt_o.parity_even   <= line_fmt_reg[LF_PAR_EVEN];
			line_fmt_o.parity_forced <= line_fmt_reg[LF_PAR_FORCE];
		end
	end

	// Same setting for both directions: the far end must match it
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tx_parity_o     <= 1'b0;
			rx_parity_err_o <= 1'b0;
		end
		else
		begin
			tx_parity_o     <= line_fmt_o.parity_en
				& parity_of(tx_char_i, line_fmt_o);
			rx_parity_err_o <= line_fmt_o.parity_en
				& (rx_parity_i != parity_of(rx_char_i, line_fmt_o));
		end
	end

endmodule

/* File: bench/uart_cfg_checker.sv */
// Purpose: Port-level timing and value checks for the channel configuration block
// Assumes: One clock domain, reset active high
// Notes:   Bound to uart_cfg from the bench top file
`timescale 1ns/1ps
module uart_cfg_checker
	import uart_cfg_pkg::*;
#(
	parameter int CNT_W = 7
)(
	input wire logic             core_clk_i,       // Clock
	input wire logic             rst_i,            // Reset
	input wire logic [5:0]       address_i,        // Bus address
	input wire logic             read_i,           // Bus read
	input wire logic             write_i,          // Bus write
	input wire logic [31:0]      writedata_i,      // Bus data
	input wire logic             waitrequest_o,    // Bus wait
	input wire logic [CNT_W-1:0] tx_count_i,       // TX fill
	input wire logic [CNT_W-1:0] rx_count_i,       // RX fill
	input wire logic [7:0]       tx_char_i,        // TX char
	input wire logic [7:0]       rx_char_i,        // RX char
	input wire logic             rx_parity_i,      // RX parity
	input wire logic             tx_fifo_clear_o,  // Clear pulse
	input wire logic             tx_ready_pin_n_o, // TX ready
	input wire logic             rx_ready_pin_n_o, // RX ready
	input wire trig_cfg_t        trig_cfg_o,       // Trigger setup
	input wire line_format_t     line_fmt_o,       // Line format
	input wire logic             tx_parity_o,      // TX parity
	input wire logic             rx_parity_err_o   // RX parity bad
);
	logic clr_wr;
	assign clr_wr = write_i && !waitrequest_o && address_i == OFS_FIFO_CTL
		&& writedata_i[0] && writedata_i[2];

	// Upper data bits beyond the word length are masked out
	function automatic logic par(input line_format_t f, input logic [7:0] c);
		logic [7:0] m;
		m = 8'hff >> (4'h8 - f.data_bits);
		if (!f.parity_en)
			return 1'b0;
		return f.parity_forced ? !f.parity_even : ^(c & m) ^ !f.parity_even;
	endfunction

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////
	sequence s_req;
		$rose(read_i || write_i);
	endsequence
	sequence s_normal;
		!rst_i && !trig_cfg_o.dma_mode ##1 !trig_cfg_o.dma_mode;
	endsequence
	sequence s_dma;
		trig_cfg_o.dma_mode [*2];
	endsequence
	property p_one_wait;
		s_req |-> waitrequest_o ##1 !waitrequest_o;
	endproperty
	property p_clr;
		clr_wr |=> tx_fifo_clear_o ##1 !tx_fifo_clear_o;
	endproperty
	property p_clr_cause;
		$rose(tx_fifo_clear_o) |-> $past(clr_wr);
	endproperty
	property p_stop;
		line_fmt_o.stop_half_bits != STOP_ONE |-> line_fmt_o.stop_half_bits
			== (line_fmt_o.data_bits == 4'h5 ? 3'h3 : 3'h4);
	endproperty
	property p_txpar;
		$stable(line_fmt_o) |=> tx_parity_o == par($past(line_fmt_o), $past(tx_char_i));
	endproperty
	property p_rxerr;
		$stable(line_fmt_o) |=> rx_parity_err_o == ($past(line_fmt_o.parity_en)
			&& par($past(line_fmt_o), $past(rx_char_i)) != $past(rx_parity_i));
	endproperty
	property p_rdy_norm;
		s_normal |-> rx_ready_pin_n_o == ($past(rx_count_i) == 0)
			&& tx_ready_pin_n_o == ($past(tx_count_i) != 0);
	endproperty
	property p_rdy_dma;
		s_dma |-> rx_ready_pin_n_o == ($past(rx_count_i) < $past(trig_cfg_o.rx_level))
			&& tx_ready_pin_n_o == ($past(tx_count_i) >= 7'h40);
	endproperty
	property p_tab_a;
		trig_cfg_o.table_sel == TABLE_A |-> trig_cfg_o.tx_level == 7'h01
			&& trig_cfg_o.rx_level inside {7'h01, 7'h04, 7'h08, 7'h0e};
	endproperty
	property p_tab_b;
		trig_cfg_o.table_sel == TABLE_B |-> trig_cfg_o.tx_level inside {7'h10, 7'h08, 7'h18, 7'h1e}
			&& trig_cfg_o.rx_level inside {7'h08, 7'h10, 7'h18, 7'h1c};
	endproperty
	property p_tab_c;
		trig_cfg_o.table_sel == TABLE_C |-> trig_cfg_o.tx_level inside {7'h08, 7'h10, 7'h20, 7'h38}
			&& trig_cfg_o.rx_level inside {7'h08, 7'h10, 7'h38, 7'h3c};
	endproperty

	////////////////////////////////////////////////////////////////////////////
	a_one_wait: assert property (p_one_wait) else $error("bus wait not one cycle");
	a_clr: assert property (p_clr) else $error("clear pulse missing");
	a_clr_cause: assert property (p_clr_cause) else $error("clear without enable");
	a_stop: assert property (p_stop) else $error("stop length wrong");
	a_txpar: assert property (p_txpar) else $error("tx parity wrong");
	a_rxerr: assert property (p_rxerr) else $error("rx parity flag wrong");
	a_rdy_norm: assert property (p_rdy_norm) else $error("ready pins normal");
	a_rdy_dma: assert property (p_rdy_dma) else $error("ready pins dma");
	a_tab_a: assert property (p_tab_a) else $error("table A level");
	a_tab_b: assert property (p_tab_b) else $error("table B level");
	a_tab_c: assert property (p_tab_c) else $error("table C level");
endmodule

/* File: bench/fifo_far_model.sv */
// Purpose: Far side stand-in: FIFO fill counts and the remote sender's parity
// Assumes: Fill levels are loaded by the bench
// Notes:   Sends wrong parity when either bad_i is high or a short unforced-parity word has an odd count of upper char bits set, not both
`timescale 1ns/1ps
module fifo_far_model
	import uart_cfg_pkg::*;
(
	input  wire logic         core_clk_i, // Clock
	input  wire logic         rst_i,      // Reset
	input  wire logic         load_i,     // Take new fills
	input  wire logic [6:0]   tx_lvl_i,   // TX fill to set
	input  wire logic [6:0]   rx_lvl_i,   // RX fill to set
	input  wire logic         clear_i,    // TX pointer clear
	input  wire line_format_t fmt_i,      // Agreed format
	input  wire logic [7:0]   char_i,     // Char sent in
	input  wire logic         bad_i,      // Corrupt parity
	output logic [6:0]        tx_count_o, // TX fill
	output logic [6:0]        rx_count_o, // RX fill
	output logic              parity_o    // Parity sent
);
	// Clear wins over a load; the receive side is left alone
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tx_count_o <= 7'h00;
			rx_count_o <= 7'h00;
		end
		else if (clear_i)
			tx_count_o <= 7'h00;
		else if (load_i)
		begin
			tx_count_o <= tx_lvl_i;
			rx_count_o <= rx_lvl_i;
		end
	end

	// Remote end uses the block's parity settings but takes parity over all eight char bits
	assign parity_o = bad_i ^ (fmt_i.parity_forced ? !fmt_i.parity_even
		: ^char_i ^ !fmt_i.parity_even);
endmodule

/* File: bench/tb.sv */
// Purpose: Self-checking bench for the channel configuration block
// Assumes: Bus answers with one wait cycle
// Notes:   Trigger table cases run from a row table
`timescale 1ns/1ps
module tb;
	import uart_cfg_pkg::*;
	typedef struct packed {logic [1:0] tab; logic [1:0] code; level_t rx; level_t tx;} row_t;
	localparam int CNT_W = 7;
	logic         core_clk_i = 1'b0;
	logic         rst_i = 1'b1;
	logic [5:0]   address_i = 6'h00;
	logic         read_i = 1'b0, write_i = 1'b0, load = 1'b0, bad = 1'b0;
	logic [31:0]  writedata_i = 32'h0, readdata_o, q;
	logic [6:0]   tx_count_i, rx_count_i, tx_lvl = 7'h00, rx_lvl = 7'h00;
	logic [7:0]   tx_char_i = 8'h00, rx_char_i = 8'h00;
	logic         waitrequest_o, rx_parity_i, tx_fifo_clear_o, irq_o;
	logic         tx_ready_pin_n_o, rx_ready_pin_n_o, tx_parity_o, rx_parity_err_o;
	trig_cfg_t    trig_cfg_o;
	line_format_t line_fmt_o;
	int           miscompares = 0, checks_done = 0;
	logic [7:0]   fm [5] = '{8'h03, 8'h0b, 8'h1b, 8'h2b, 8'h3b};
	row_t         rows [12] = '{'{2'h0, 2'h0, 7'h01, 7'h01}, '{2'h0, 2'h1, 7'h04, 7'h01},
		'{2'h0, 2'h2, 7'h08, 7'h01}, '{2'h0, 2'h3, 7'h0e, 7'h01}, '{2'h1, 2'h0, 7'h08, 7'h10},
		'{2'h1, 2'h1, 7'h10, 7'h08}, '{2'h1, 2'h2, 7'h18, 7'h18}, '{2'h1, 2'h3, 7'h1c, 7'h1e},
		'{2'h2, 2'h0, 7'h08, 7'h08}, '{2'h2, 2'h1, 7'h10, 7'h10}, '{2'h2, 2'h2, 7'h38, 7'h20},
		'{2'h2, 2'h3, 7'h3c, 7'h38}};

	always #10 core_clk_i = ~core_clk_i;

	uart_cfg #(.CNT_W(CNT_W)) i_dut (.core_clk_i, .rst_i, .address_i, .read_i, .write_i,
		.writedata_i, .readdata_o, .waitrequest_o, .tx_count_i, .rx_count_i, .tx_char_i,
		.rx_char_i, .rx_parity_i, .tx_fifo_clear_o, .tx_ready_pin_n_o, .rx_ready_pin_n_o,
		.trig_cfg_o, .line_fmt_o, .tx_parity_o, .rx_parity_err_o, .irq_o);
	fifo_far_model i_far (.core_clk_i, .rst_i, .load_i(load), .tx_lvl_i(tx_lvl),
		.rx_lvl_i(rx_lvl), .clear_i(tx_fifo_clear_o), .fmt_i(line_fmt_o), .char_i(rx_char_i),
		.bad_i(bad), .tx_count_o(tx_count_i), .rx_count_o(rx_count_i), .parity_o(rx_parity_i));

	////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
			miscompares++;
		end
	endtask
	// Request held until a rising edge sees wait low; data taken at that same edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk_i);
		address_i <= a;
		writedata_i <= d;
		write_i <= wr;
		read_i <= !wr;
		n = 0;
		do
		begin
			@(posedge core_clk_i);
			n++;
		end
		while (waitrequest_o !== 1'b0 && n < 20);
		if (waitrequest_o !== 1'b0)
		begin
			miscompares++;
			end_of_test();
		end
		q = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(nm, q, exp);
	endtask
	task automatic set_lv(input logic [6:0] t, input logic [6:0] r);
		@(posedge core_clk_i);
		load <= 1'b1;
		tx_lvl <= t;
		rx_lvl <= r;
		@(posedge core_clk_i);
		load <= 1'b0;
	endtask
	// Register, format and parity stages each add one edge
	task automatic at_ports();
		repeat (3) @(negedge core_clk_i);
	endtask
	function automatic logic ep(input logic [7:0] f, input logic [7:0] c);
		if (!f[3])
			return 1'b0;
		return f[5] ? !f[4] : ^c ^ !f[4];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd("trigger status", OFS_TRIG_STAT, 32'h00000101);
		rd("line format", OFS_LINE_FMT, 32'h0);
		rd("fifo control", OFS_FIFO_CTL, 32'h0);
		wr(6'h3c, 32'hff);
		rd("unmapped", 6'h3c, 32'h0);
		$display("test reset done");
		wr(OFS_ENHANCED, 32'h10);
		foreach (rows[i])
		begin
			wr(OFS_FEATURE, {26'h0, rows[i].tab, 4'h0});
			wr(OFS_FIFO_CTL, {24'h0, rows[i].code, rows[i].code, 4'h1});
			rd("levels", OFS_TRIG_STAT, {13'h1, 1'b0, rows[i].tab, 1'b0, rows[i].tx, 1'b0,
				rows[i].rx});
		end
		$display("test trigger tables done");
		// TX select must hold its old code while the enhanced bit is off
		wr(OFS_ENHANCED, 32'h0);
		wr(OFS_FEATURE, 32'h10);
		wr(OFS_FIFO_CTL, 32'h01);
		rd("locked tx", OFS_TRIG_STAT, 32'h00091e08);
		wr(OFS_FIFO_CTL, 32'hc8);
		rd("no enable", OFS_TRIG_STAT, 32'h00011e08);
		wr(OFS_FEATURE, 32'h30);
		wr(OFS_TRIG_LEVEL, 32'h20);
		rd("prog rx", OFS_TRIG_LEVEL, 32'h20);
		wr(OFS_FEATURE, 32'hb0);
		wr(OFS_TRIG_LEVEL, 32'h2a);
		rd("prog tx", OFS_TRIG_LEVEL, 32'h2a);
		wr(OFS_FIFO_CTL, 32'hf1);
		rd("table D", OFS_TRIG_STAT, 32'h000b2a20);
		$display("test selects done");
		set_lv(7'h05, 7'h00);
		wr(OFS_FIFO_CTL, 32'h04);
		at_ports();
		chk("tx fill kept", tx_count_i, 32'h5);
		wr(OFS_FIFO_CTL, 32'h05);
		at_ports();
		chk("tx fill cleared", tx_count_i, 32'h0);
		$display("test tx reset done");
		wr(OFS_ENHANCED, 32'h10);
		wr(OFS_FEATURE, 32'h10);
		wr(OFS_FIFO_CTL, 32'h01);
		wr(OFS_IRQ_ENABLE, 32'h3);
		set_lv(7'h00, 7'h07);
		wr(OFS_IRQ_CLEAR, 32'h3);
		rd("status", OFS_IRQ_STATUS, 32'h0);
		set_lv(7'h00, 7'h08);
		rd("status", OFS_IRQ_STATUS, 32'h1);
		chk("irq", irq_o, 32'h1);
		wr(OFS_IRQ_ENABLE, 32'h2);
		at_ports();
		chk("irq masked", irq_o, 32'h0);
		wr(OFS_IRQ_CLEAR, 32'h1);
		rd("status", OFS_IRQ_STATUS, 32'h0);
		set_lv(7'h08, 7'h08);
		set_lv(7'h00, 7'h08);
		rd("status", OFS_IRQ_STATUS, 32'h2);
		chk("irq", irq_o, 32'h1);
		wr(OFS_IRQ_CLEAR, 32'h2);
		set_lv(7'h14, 7'h08);
		set_lv(7'h0a, 7'h08);
		rd("status", OFS_IRQ_STATUS, 32'h2);
		$display("test interrupts done");
		for (int i = 0; i < 8; i++)
		begin
			wr(OFS_LINE_FMT, i);
			at_ports();
			chk("data bits", line_fmt_o.data_bits, 5 + i[1:0]);
			chk("stop", line_fmt_o.stop_half_bits, !i[2] ? 2 : (i[1:0] == 0 ? 3 : 4));
		end
		rd("line format", OFS_LINE_FMT, 32'h7);
		foreach (fm[j])
		begin
			wr(OFS_LINE_FMT, fm[j]);
			tx_char_i <= 8'h07;
			rx_char_i <= 8'h35;
			bad <= 1'b0;
			at_ports();
			chk("tx parity", tx_parity_o, ep(fm[j], 8'h07));
			chk("rx parity flag", rx_parity_err_o, 32'h0);
			@(posedge core_clk_i);
			bad <= 1'b1;
			at_ports();
			chk("rx parity flag", rx_parity_err_o, fm[j][3]);
		end
		$display("test line format done");
		wr(OFS_FIFO_CTL, 32'h09);
		set_lv(7'h0a, 7'h07);
		at_ports();
		chk("tx ready dma", tx_ready_pin_n_o, 32'h0);
		chk("rx ready dma", rx_ready_pin_n_o, 32'h1);
		wr(OFS_FIFO_CTL, 32'h01);
		at_ports();
		chk("tx ready", tx_ready_pin_n_o, 32'h1);
		chk("rx ready", rx_ready_pin_n_o, 32'h0);
		$display("test ready pins done");
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd("trigger status", OFS_TRIG_STAT, 32'h00000101);
		rd("line format", OFS_LINE_FMT, 32'h0);
		chk("ready pins", {tx_ready_pin_n_o, rx_ready_pin_n_o}, 32'h1);
		$display("test second reset done");
		end_of_test();
	end
endmodule

bind uart_cfg uart_cfg_checker #(.CNT_W(CNT_W)) i_chk (.core_clk_i, .rst_i, .address_i,
	.read_i, .write_i, .writedata_i, .waitrequest_o, .tx_count_i, .rx_count_i, .tx_char_i,
	.rx_char_i, .rx_parity_i, .tx_fifo_clear_o, .tx_ready_pin_n_o, .rx_ready_pin_n_o,
	.trig_cfg_o, .line_fmt_o, .tx_parity_o, .rx_parity_err_o);
